// ===== inc/spm_regs.vh
// register offsets, field positions, config port addresses and fan duty values for the serial pin strap mux
`ifndef SPM_REGS_VH
`define SPM_REGS_VH
`define SPM_OFF_STRAP      12'h000
`define SPM_OFF_ADDR       12'h004
`define SPM_OFF_CFGPORT    12'h008
`define SPM_OFF_MSR_BASE   12'h010
`define SPM_OFF_MCR_BASE   12'h030
`define SPM_OFF_GPSEL_BASE 12'h050
`define SPM_OFF_GPOUT_BASE 12'h060
`define SPM_OFF_GPIN_BASE  12'h070
`define SPM_OFF_FDC        12'h080
`define SPM_OFF_UART_OUT   12'h084
`define SPM_STRAP_FDC_BIT  1
`define SPM_STRAP_KBC_BIT  2
`define SPM_ADDR_SEL_BIT   6
`define SPM_MSR_CTS_BIT    4
`define SPM_MSR_DSR_BIT    5
`define SPM_MSR_RI_BIT     6
`define SPM_MSR_DCD_BIT    7
`define SPM_CFG_ADDR_LO    16'h002E
`define SPM_CFG_ADDR_HI    16'h004E
`define SPM_FAN_HALF       8'h80
`define SPM_FAN_FULL       8'hFF
`endif

// ===== src/spm_sync2.v
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module spm_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end
  assign q = sync_reg;
endmodule // spm_sync2
`default_nettype wire

// ===== src/spm_pin_mux.v
// serial port pin sharing, power-on strap capture and apb register file
`timescale 1ns/1ps
`default_nettype none
`include "spm_regs.vh"
module spm_pin_mux #(
  parameter NPORT = 6,
  parameter NGP = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire config_addr_strap,
  input wire floppy_or_uartf_strap,
  input wire kbd_ctrl_enable_strap,
  input wire fan_speed_strap,
  input wire beep_led_gpio_select_strap,
  input wire [NPORT-1:0] cts_n_in,
  input wire [NPORT-1:0] dsr_n_in,
  input wire [NPORT-1:0] dcd_n_in,
  input wire [NPORT-1:0] ri_n_in,
  input wire [NPORT-1:0] serial_in,
  input wire infrared_receive_in,
  output wire [NPORT-1:0] rts_n_out,
  output wire [NPORT-1:0] dtr_n_out,
  output wire [NPORT-1:0] serial_out,
  output wire [NGP*8-1:0] gpio_oe_n,
  output wire infrared_transmit_out,
  output wire drive_a_select_n_out,
  output wire drive_a_select_n_oe_n,
  output wire motor_a_on_n_out,
  output wire motor_a_on_n_oe_n,
  output wire head_dir_out,
  output wire head_dir_oe_n,
  output wire head_side_out,
  output wire head_side_oe_n,
  output wire step_n_out,
  output wire step_n_oe_n,
  output wire floppy_write_data_n_out,
  output wire floppy_write_data_n_oe_n,
  output wire write_enable_n_out,
  output wire write_enable_n_oe_n,
  output wire floppy_enable,
  output wire keyboard_controller_enable,
  output wire [7:0] fan_initial_duty,
  output wire beep_out,
  output wire beep_oe_n,
  output wire power_led_out,
  output wire power_led_oe_n,
  output wire [15:0] config_index_port,
  output wire [15:0] config_data_port
);

////////////////////////////////////////////////////////////////////////////////
// strap capture: straps are sampled after reset release, once settle_reg reaches 3, and then frozen
  wire [4:0] strap_sync;
  reg [4:0] strap_reg;
  reg strap_done_reg;
  spm_sync2 #(.WIDTH(5), .INIT(5'h00)) u_strap_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({beep_led_gpio_select_strap, fan_speed_strap, kbd_ctrl_enable_strap,
        floppy_or_uartf_strap, config_addr_strap}),
    .q(strap_sync)
  );
  // the synchroniser runs through the sync delay, then one clocked capture freezes it;
  // later pin activity never reaches strap_reg
  reg [1:0] settle_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      strap_reg <= 5'h00;
    end else begin
      if (settle_reg != 2'h3) begin
        settle_reg <= settle_reg + 2'h1;
      end
      if (settle_reg == 2'h3 && !strap_done_reg) begin
        strap_reg <= strap_sync;
        strap_done_reg <= 1'b1;
      end
    end
  end
  // straps are sampled again after every release of the active-low presetn, not just at power-on; the pins carry
  // their resistor level at that time because the sync chain is reset-clean

  wire addr_strap = strap_reg[0];
  assign floppy_enable = strap_done_reg & ~strap_reg[1];
  assign keyboard_controller_enable = strap_reg[2];
  assign fan_initial_duty = strap_reg[3] ? `SPM_FAN_FULL : `SPM_FAN_HALF;
  wire gpio_mode_27 = strap_reg[4];

  wire [15:0] cfg_base = addr_strap ? `SPM_CFG_ADDR_HI : `SPM_CFG_ADDR_LO;
  assign config_index_port = cfg_base;
  assign config_data_port = cfg_base + 16'h0001;

////////////////////////////////////////////////////////////////////////////////
// modem input synchronisers
  wire [NPORT-1:0] cts_s, dsr_s, dcd_s, ri_s;
  wire ir_s;
  spm_sync2 #(.WIDTH(4*NPORT+1), .INIT({(4*NPORT+1){1'b1}})) u_modem_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({infrared_receive_in, ri_n_in, dcd_n_in, dsr_n_in, cts_n_in}),
    .q({ir_s, ri_s, dcd_s, dsr_s, cts_s})
  );
  wire [NPORT-1:0] sin_s;
  spm_sync2 #(.WIDTH(NPORT), .INIT({NPORT{1'b1}})) u_sin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(serial_in),
    .q(sin_s)
  );

////////////////////////////////////////////////////////////////////////////////
// software state
  reg [1:0] mcr_reg [0:NPORT-1];
  reg [NPORT-1:0] sout_reg;
  reg [7:0] gpsel_reg [0:NGP-1];
  reg [7:0] gpout_reg [0:NGP-1];
  reg [5:0] fdc_reg;
  reg [1:0] misc_reg;

  wire access = psel & penable;
  wire wr = access & pwrite;
  assign pready = 1'b1;

////////////////////////////////////////////////////////////////////////////////
// per-port modem control and status
  wire [7:0] msr_word [0:NPORT-1];
  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_port
      // status bits report asserted (pin low) as one
      assign msr_word[gi] = {~dcd_s[gi], ~ri_s[gi], ~dsr_s[gi], ~cts_s[gi], 4'h0};
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mcr_reg[gi] <= 2'h0;
        end else if (wr && paddr == `SPM_OFF_MCR_BASE + 4 * gi) begin
          mcr_reg[gi] <= pwdata[1:0];
        end
      end
      // mcr bit0 = dtr ready, bit1 = rts ready; ready drives the pin low
      assign dtr_n_out[gi] = ~mcr_reg[gi][0];
      assign rts_n_out[gi] = ~mcr_reg[gi][1];
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sout_reg <= {NPORT{1'b1}};
      misc_reg <= 2'h0;
      fdc_reg <= 6'h3F;
    end else if (wr && paddr == `SPM_OFF_UART_OUT) begin
      sout_reg <= pwdata[NPORT-1:0];
      misc_reg[0] <= pwdata[8];
    end else if (wr && paddr == `SPM_OFF_FDC) begin
      fdc_reg <= pwdata[5:0];
    end else if (wr && paddr == `SPM_OFF_CFGPORT) begin
      misc_reg[1] <= pwdata[0];
    end
  end
  assign infrared_transmit_out = misc_reg[0];

////////////////////////////////////////////////////////////////////////////////
// gpio sharing for ports B..E: only a selected bit 2 stops driving its serial function (serial out)
  generate
    for (gi = 0; gi < NGP; gi = gi + 1) begin : g_gp
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gpsel_reg[gi] <= 8'h00;
          gpout_reg[gi] <= 8'hFF;
        end else if (wr && paddr == `SPM_OFF_GPSEL_BASE + 4 * gi) begin
          gpsel_reg[gi] <= pwdata[7:0];
        end else if (wr && paddr == `SPM_OFF_GPOUT_BASE + 4 * gi) begin
          gpout_reg[gi] <= pwdata[7:0];
        end
      end
      // open-drain gpio: enable (low) only when selected and driving zero
      assign gpio_oe_n[gi*8 +: 8] = ~(gpsel_reg[gi] & ~gpout_reg[gi]);
    end
  endgenerate

  // port F serial out is silenced when floppy owns the pins
  genvar si;
  generate
    for (si = 0; si < NPORT; si = si + 1) begin : g_sout
      if (si == NPORT - 1) begin : g_f
        assign serial_out[si] = floppy_enable ? 1'b1 : sout_reg[si];
      end else if (si == 0) begin : g_a
        assign serial_out[si] = sout_reg[si];
      end else begin : g_shared
        // bit 2 of each gpio port shares the serial output pin
        assign serial_out[si] = gpsel_reg[si-1][2] ? gpout_reg[si-1][2] : sout_reg[si];
      end
    end
  endgenerate

////////////////////////////////////////////////////////////////////////////////
// floppy outputs, open drain: enable low drives the pin low, else released high
  // fdc_reg: 0 dsel_n 1 motor_n 2 dir 3 head 4 step_n 5 wdata_n ; wenable reuses misc
  assign drive_a_select_n_out = 1'b0;
  assign drive_a_select_n_oe_n = fdc_reg[0];
  assign motor_a_on_n_out = 1'b0;
  assign motor_a_on_n_oe_n = fdc_reg[1];
  assign head_dir_out = 1'b0;
  assign head_dir_oe_n = fdc_reg[2];
  assign head_side_out = 1'b0;
  assign head_side_oe_n = fdc_reg[3];
  assign step_n_out = 1'b0;
  assign step_n_oe_n = ~floppy_enable | fdc_reg[4];
  assign floppy_write_data_n_out = 1'b0;
  assign floppy_write_data_n_oe_n = ~floppy_enable | fdc_reg[5];
  assign write_enable_n_out = 1'b0;
  assign write_enable_n_oe_n = ~floppy_enable | ~misc_reg[1];

////////////////////////////////////////////////////////////////////////////////
// beep with the power led held released, or plain outputs for both when the strap selects gpio
  assign beep_out = 1'b0;
  assign power_led_out = 1'b0;
  assign beep_oe_n = gpio_mode_27 ? gpout_reg[0][1] : ~misc_reg[0];
  assign power_led_oe_n = gpio_mode_27 ? gpout_reg[0][0] : 1'b1;

////////////////////////////////////////////////////////////////////////////////
// apb read decode, zero wait state; unmapped reads zero and flag pslverr
  reg [31:0] rdata_next;
  reg err_next;
  integer k;
  always @* begin
    rdata_next = 32'h00000000;
    err_next = 1'b1;
    if (paddr == `SPM_OFF_STRAP) begin
      rdata_next[`SPM_STRAP_FDC_BIT] = strap_reg[1];
      rdata_next[`SPM_STRAP_KBC_BIT] = strap_reg[2];
      rdata_next[3] = strap_reg[3];
      rdata_next[4] = strap_reg[4];
      err_next = 1'b0;
    end else if (paddr == `SPM_OFF_ADDR) begin
      rdata_next[`SPM_ADDR_SEL_BIT] = addr_strap;
      err_next = 1'b0;
    end else if (paddr == `SPM_OFF_CFGPORT) begin
      rdata_next[15:0] = cfg_base;
      err_next = 1'b0;
    end else if (paddr == `SPM_OFF_FDC) begin
      rdata_next[5:0] = fdc_reg;
      err_next = 1'b0;
    end else if (paddr == `SPM_OFF_UART_OUT) begin
      rdata_next[NPORT-1:0] = sout_reg;
      rdata_next[8] = misc_reg[0];
      rdata_next[16+NPORT-1:16] = sin_s;
      rdata_next[24] = ir_s;
      err_next = 1'b0;
    end else begin
      for (k = 0; k < NPORT; k = k + 1) begin
        if (paddr == `SPM_OFF_MSR_BASE + 4 * k) begin
          rdata_next[7:0] = msr_word[k];
          err_next = 1'b0;
        end
        if (paddr == `SPM_OFF_MCR_BASE + 4 * k) begin
          rdata_next[1:0] = mcr_reg[k];
          err_next = 1'b0;
        end
      end
      for (k = 0; k < NGP; k = k + 1) begin
        if (paddr == `SPM_OFF_GPSEL_BASE + 4 * k) begin
          rdata_next[7:0] = gpsel_reg[k];
          err_next = 1'b0;
        end
        if (paddr == `SPM_OFF_GPOUT_BASE + 4 * k) begin
          rdata_next[7:0] = gpout_reg[k];
          err_next = 1'b0;
        end
        if (paddr == `SPM_OFF_GPIN_BASE + 4 * k) begin
          // bit order follows the shared pins: cts dsr rts dtr sin sout dcd ri
          rdata_next[7:0] = {~cts_s[k+1], ~dsr_s[k+1], ~rts_n_out[k+1], ~dtr_n_out[k+1],
                             sin_s[k+1], sout_reg[k+1], ~dcd_s[k+1], ~ri_s[k+1]};
          err_next = 1'b0;
        end
      end
    end
  end

  reg [31:0] prdata_reg;
  reg pslverr_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      prdata_reg <= pwrite ? 32'h00000000 : rdata_next;
      pslverr_reg <= err_next;
    end
  end
  assign prdata = prdata_reg;
  assign pslverr = access & pslverr_reg;

endmodule // spm_pin_mux
`default_nettype wire

// ===== testbench/spm_far_model.sv
// behavioural modem, strap resistors and floppy drive on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module spm_far_model (
  input wire logic [23:0] modem_on,
  input wire logic [4:0] strap_fit,
  input wire logic [5:0] sout,
  input wire logic ir_tx,
  input wire logic [6:0] fd_out,
  input wire logic [6:0] fd_oe_n,
  output logic [5:0] cts_n,
  output logic [5:0] dsr_n,
  output logic [5:0] ri_n,
  output logic [5:0] dcd_n,
  output logic [5:0] sin,
  output logic ir_rx,
  output logic [4:0] strap_pin,
  output logic [6:0] fd_pin
);
  // modem asserts a line by pulling it low
  assign cts_n = ~modem_on[5:0];
  assign dsr_n = ~modem_on[11:6];
  assign ri_n = ~modem_on[17:12];
  assign dcd_n = ~modem_on[23:18];
  // far end echoes what it hears
  assign sin = sout;
  assign ir_rx = ir_tx;
  // unfitted strap falls to the internal pull-down
  assign strap_pin = strap_fit;
  // drive inputs pull released open-drain lines high
  assign fd_pin = fd_out | fd_oe_n;
endmodule // spm_far_model
`default_nettype wire

// ===== testbench/spm_pin_mux_sva.sv
// port assertions for the serial pin strap mux
`timescale 1ns/1ps
`default_nettype none
module spm_pin_mux_sva #(
  parameter NPORT = 6,
  parameter NGP = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [NPORT-1:0] serial_out,
  input wire drive_a_select_n_out,
  input wire motor_a_on_n_out,
  input wire head_dir_out,
  input wire head_side_out,
  input wire step_n_oe_n,
  input wire floppy_write_data_n_oe_n,
  input wire write_enable_n_oe_n,
  input wire floppy_enable,
  input wire keyboard_controller_enable,
  input wire [7:0] fan_initial_duty,
  input wire [15:0] config_index_port,
  input wire [15:0] config_data_port
);
  logic [3:0] up_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // counts edges since release so strap checks skip the capture window
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) up_cnt <= 4'h0;
    else if (up_cnt != 4'hF) up_cnt <= up_cnt + 4'h1;
  end
  a_strap_held: assert property ((up_cnt > 4'h6) |-> $stable(fan_initial_duty)
    && $stable(config_index_port) && $stable(floppy_enable)
    && $stable(keyboard_controller_enable)) else $error("strap value moved");
  a_fan_value: assert property ((up_cnt > 4'h6) |->
    (fan_initial_duty == 8'h80 || fan_initial_duty == 8'hFF)) else $error("bad fan duty");
  a_cfg_addr: assert property (config_index_port == 16'h002E
    || config_index_port == 16'h004E) else $error("bad config port");
  a_cfg_data_next: assert property (config_data_port == config_index_port + 16'h0001)
    else $error("data port not index plus one");
  a_uartf_blocked: assert property (floppy_enable |-> serial_out[5])
    else $error("port F output active in floppy mode");
  a_floppy_idle: assert property (!floppy_enable |-> (step_n_oe_n &&
    floppy_write_data_n_oe_n && write_enable_n_oe_n)) else $error("floppy pin driven");
  a_od_only_low: assert property (!(drive_a_select_n_out || motor_a_on_n_out
    || head_dir_out || head_side_out)) else $error("open-drain pin driven high");
  a_zero_wait: assert property (psel && penable |-> pready) else $error("wait state seen");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("stray slave error");
  c_floppy: cover property (floppy_enable && !step_n_oe_n);
  c_uartf: cover property (!floppy_enable && keyboard_controller_enable);
  c_err: cover property (pslverr);
endmodule // spm_pin_mux_sva
bind spm_pin_mux spm_pin_mux_sva #(.NPORT(NPORT), .NGP(NGP)) u_spm_pin_mux_sva (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .serial_out,
  .drive_a_select_n_out, .motor_a_on_n_out, .head_dir_out, .head_side_out,
  .step_n_oe_n, .floppy_write_data_n_oe_n, .write_enable_n_oe_n, .floppy_enable,
  .keyboard_controller_enable, .fan_initial_duty, .config_index_port, .config_data_port);
`default_nettype wire

// ===== testbench/spm_pin_mux_tb.sv
// register level bench for the serial pin strap mux
`timescale 1ns/1ps
`default_nettype none
`include "spm_regs.vh"
module spm_pin_mux_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, infrared_receive_in, infrared_transmit_out;
  logic [23:0] modem_on = 24'h0;
  logic [4:0] strap_fit = 5'h00, strap_pin;
  logic [5:0] cts_n_in, dsr_n_in, dcd_n_in, ri_n_in, serial_in, rts_n_out, dtr_n_out, serial_out;
  logic [31:0] gpio_oe_n;
  logic [6:0] fd_out, fd_oe_n, fd_pin;
  logic floppy_enable, keyboard_controller_enable, beep_out, beep_oe_n, power_led_out;
  logic power_led_oe_n;
  logic [7:0] fan_initial_duty;
  logic [15:0] config_index_port, config_data_port;
  int error_cnt = 0, checks_done = 0;
  initial forever #12.5 pclk = ~pclk;
  spm_pin_mux u_spm_pin_mux (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .config_addr_strap(strap_pin[0]),
    .floppy_or_uartf_strap(strap_pin[1]), .kbd_ctrl_enable_strap(strap_pin[2]),
    .fan_speed_strap(strap_pin[3]), .beep_led_gpio_select_strap(strap_pin[4]),
    .cts_n_in, .dsr_n_in, .dcd_n_in, .ri_n_in, .serial_in, .infrared_receive_in,
    .rts_n_out, .dtr_n_out, .serial_out, .gpio_oe_n, .infrared_transmit_out,
    .drive_a_select_n_out(fd_out[0]), .drive_a_select_n_oe_n(fd_oe_n[0]),
    .motor_a_on_n_out(fd_out[1]), .motor_a_on_n_oe_n(fd_oe_n[1]),
    .head_dir_out(fd_out[2]), .head_dir_oe_n(fd_oe_n[2]), .head_side_out(fd_out[3]),
    .head_side_oe_n(fd_oe_n[3]), .step_n_out(fd_out[4]), .step_n_oe_n(fd_oe_n[4]),
    .floppy_write_data_n_out(fd_out[5]), .floppy_write_data_n_oe_n(fd_oe_n[5]),
    .write_enable_n_out(fd_out[6]), .write_enable_n_oe_n(fd_oe_n[6]), .floppy_enable,
    .keyboard_controller_enable, .fan_initial_duty, .beep_out, .beep_oe_n, .power_led_out,
    .power_led_oe_n, .config_index_port, .config_data_port);
  spm_far_model u_spm_far_model (.modem_on, .strap_fit, .sout(serial_out),
    .ir_tx(infrared_transmit_out), .fd_out, .fd_oe_n, .cts_n(cts_n_in), .dsr_n(dsr_n_in),
    .ri_n(ri_n_in), .dcd_n(dcd_n_in), .sin(serial_in), .ir_rx(infrared_receive_in),
    .strap_pin, .fd_pin);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // holds the request through the access phase until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 50);
    if (i < 50) begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end else begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic settle(); repeat (3) @(posedge pclk); #1; endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    end_sim();
  end
  initial begin
    for (int s = 0; s < 2; s++) begin
      @(posedge pclk);
      presetn <= 1'b0; strap_fit <= s ? 5'h1F : 5'h00; modem_on <= 24'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      strap_fit <= s ? 5'h00 : 5'h1F;
      settle();
      apb(0, `SPM_OFF_STRAP, 0); chk("strap", r, s ? 32'h1E : 32'h0);
      apb(0, `SPM_OFF_ADDR, 0); chk("addr", r, s ? 32'h40 : 32'h0);
      apb(0, `SPM_OFF_CFGPORT, 0); chk("cfgport", r, s ? 32'h4E : 32'h2E);
      chk("index port", config_index_port, s ? 32'h4E : 32'h2E);
      chk("data port", config_data_port, s ? 32'h4F : 32'h2F);
      chk("fan", fan_initial_duty, s ? 32'hFF : 32'h80);
      chk("modes", {floppy_enable, keyboard_controller_enable}, s ? 32'h1 : 32'h2);
      apb(1, `SPM_OFF_UART_OUT, 32'h115);
      settle();
      chk("beep", beep_oe_n, s ? 32'h1 : 32'h0);
      chk("sout", serial_out, s ? 32'h15 : 32'h35);
      apb(0, `SPM_OFF_UART_OUT, 0); chk("uart", r, s ? 32'h01150115 : 32'h01350115);
      if (s == 0) begin
        apb(1, `SPM_OFF_FDC, 32'h0A); settle();
        chk("fdc a", fd_pin, 32'h4A);
        apb(1, `SPM_OFF_FDC, 32'h35); apb(1, `SPM_OFF_CFGPORT, 32'h1); settle();
        chk("fdc b", fd_pin, 32'h35);
      end else begin
        apb(1, `SPM_OFF_FDC, 32'h0); apb(1, `SPM_OFF_CFGPORT, 32'h1); settle();
        chk("fdc off", fd_oe_n[6:4], 32'h7);
        modem_on <= {6'h30, 6'h0F, 6'h2A, 6'h15};
        settle();
        for (int n = 0; n < 6; n++) begin
          apb(0, 12'(`SPM_OFF_MSR_BASE + 4 * n), 0);
          chk("msr", r, {modem_on[18 + n], modem_on[12 + n], modem_on[6 + n], modem_on[n], 4'h0});
          apb(1, 12'(`SPM_OFF_MCR_BASE + 4 * n), 32'(n % 4));
        end
        #1;
        chk("rts dtr", {rts_n_out, dtr_n_out}, 32'hCD5);
        for (int k = 0; k < 4; k++) begin
          apb(1, 12'(`SPM_OFF_GPSEL_BASE + 4 * k), 32'hFF);
          apb(1, 12'(`SPM_OFF_GPOUT_BASE + 4 * k), 32'hA1); #1;
          chk("gpio", gpio_oe_n[8 * k +: 8], 32'hA1);
        end
        chk("shared sout", serial_out, 32'h01);
        chk("led", {beep_oe_n, power_led_oe_n}, 32'h1);
        apb(0, `SPM_OFF_GPIN_BASE, 0); chk("gpin", r, 32'h51);
        apb(0, 12'hFFC, 0); chk("unmapped", r, 32'h0);
        chk("slverr", e, 32'h1);
        apb(1, `SPM_OFF_STRAP, 0); apb(0, `SPM_OFF_STRAP, 0); chk("strap ro", r, 32'h1E);
      end
      $display("strap set %0d done", s);
    end
    end_sim();
  end
endmodule // spm_pin_mux_tb
`default_nettype wire
